/* design/roc_relay_output.sv */
/*
 * Conditioner for one binary output relay: combines up to seven assigned
 * internal signals, applies hold time, switch-off delay, latching with
 * acknowledgement and output inversion.
 * Assumes internal signals and settings come from logic on clk; the
 * settings are held steady by the surrounding configuration logic.
 */
`timescale 1ns/100ps

`include "roc_regs.svh"

// Function
// - Hold new state; delay switch-off; 10 ms steps.
// - Latching keeps picked-up relay on.
// - Acknowledgement input selectable from signal list.
// - Acknowledgement releases only while latching enabled.
// - Optional inversion of final relay drive.
// - Optional inversion per assigned input.
module roc_relay_output
    import roc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `ROC_TICK_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic [`ROC_SIG_W-1:0]     sig_list,
    input  wire roc_slot_s                 slot_cfg [`ROC_NUM_SLOTS],
    input  wire roc_cfg_s                  cfg,
    output logic                           relay_drive,
    output logic                           relay_request,
    output logic                           relay_latched
);

    // ------------------------------------------------------------------------
    // Signal selection
    // ------------------------------------------------------------------------
    function automatic logic pick(
        input logic [`ROC_SIG_W-1:0] sigs,
        input roc_sel_t              sel
    );
        if (sel == `ROC_SEL_NONE) begin
            pick = 1'b0;
        end else begin
            pick = sigs[sel];
        end
    endfunction

    logic [`ROC_NUM_SLOTS-1:0] slot_val;

    genvar g;
    generate
        for (g = 0; g < `ROC_NUM_SLOTS; g++) begin : g_slot
            wire logic assigned = (slot_cfg[g].sel != `ROC_SEL_NONE);
            wire logic picked   = pick(sig_list, slot_cfg[g].sel);
            wire logic cond     = picked ^ slot_cfg[g].invert;
            assign slot_val[g] = assigned & cond;
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Request and acknowledgement
    // ------------------------------------------------------------------------
    wire logic request  = |slot_val;
    wire logic ack_pick = pick(sig_list, cfg.ack_sel);
    wire logic ack      = cfg.latched & ack_pick;

    // ------------------------------------------------------------------------
    // Setting limits
    // ------------------------------------------------------------------------
    // Time settings above 300.00 s are treated as 300.00 s.
    function automatic roc_time_t clamp_time(input roc_time_t t);
        if (t > `ROC_TIME_MAX) begin
            clamp_time = `ROC_TIME_MAX;
        end else begin
            clamp_time = t;
        end
    endfunction

    wire roc_time_t t_hold_lim = clamp_time(cfg.t_hold);
    wire roc_time_t t_off_lim  = clamp_time(cfg.t_off_delay);

    // ------------------------------------------------------------------------
    // 10 ms tick divider
    // ------------------------------------------------------------------------
    localparam int unsigned DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    logic [DIV_W-1:0] div_r;
    wire logic        tick = (div_r == DIV_W'(TICK_CYCLES - 1));
    wire logic [DIV_W-1:0] div_nxt = tick ? '0 : div_r + 1'b1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Relay state machine
    // ------------------------------------------------------------------------
    roc_state_e state_r;
    roc_state_e state_nxt;
    roc_time_t  hold_r;
    roc_time_t  hold_nxt;
    roc_time_t  dly_r;
    roc_time_t  dly_nxt;
    logic       latch_r;
    logic       latch_nxt;

    wire logic hold_done = (hold_r == '0);
    wire logic dly_done  = (dly_r == '0);
    wire logic want_on   = request | latch_r;

    // ------------------------------------------------------------------------
    // Timer countdown
    // ------------------------------------------------------------------------
    wire roc_time_t hold_dec = (tick && !hold_done) ? hold_r - 1'b1 : hold_r;
    wire roc_time_t dly_dec  = (tick && !dly_done) ? dly_r - 1'b1 : dly_r;

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        hold_nxt  = hold_dec;
        dly_nxt   = dly_dec;
        latch_nxt = latch_r;
        if (ack && !request) begin
            latch_nxt = 1'b0;
        end
        if (!cfg.latched) begin
            latch_nxt = 1'b0;
        end
        case (state_r)
            ROC_OFF: begin
                if (want_on && hold_done) begin
                    state_nxt = ROC_ON;
                    hold_nxt  = t_hold_lim;
                    latch_nxt = cfg.latched;
                end
            end
            ROC_ON: begin
                if (cfg.latched && request) begin
                    latch_nxt = 1'b1;
                end
                if (!want_on) begin
                    state_nxt = ROC_OFF_DLY;
                    dly_nxt   = t_off_lim;
                end
            end
            ROC_OFF_DLY: begin
                if (want_on) begin
                    state_nxt = ROC_ON;
                end else if (dly_done && hold_done) begin
                    state_nxt = ROC_OFF;
                    hold_nxt  = t_hold_lim;
                end
            end
            default: begin
                state_nxt = ROC_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ROC_OFF;
            latch_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            latch_r <= latch_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Timer registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_r <= `ROC_TIME_DEF;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dly_r <= `ROC_TIME_DEF;
        end else begin
            dly_r <= dly_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Off state drives low unless the output is inverted; during reset relay_drive is low either way.
    wire logic drive_nxt = (state_nxt != ROC_OFF) ^ cfg.out_invert;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            relay_drive <= 1'b0;
        end else begin
            relay_drive <= drive_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            relay_request <= 1'b0;
        end else begin
            relay_request <= request;
        end
    end

    // The latch flag is shown as it is held.
    assign relay_latched = latch_r;

endmodule

/* common/roc_regs.svh */
/*
 * Constants for the relay output conditioner: slot counts, defaults and timing.
 * Assumes a 125 MHz system clock; included by bare name.
 */
`ifndef ROC_REGS_SVH
`define ROC_REGS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define ROC_NUM_SLOTS      7
`define ROC_SIG_W          8
`define ROC_SEL_W          3
`define ROC_TIME_W         15
// Selector value meaning no signal assigned.
`define ROC_SEL_NONE       3'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ROC_CLK_MHZ        125
`define ROC_TICK_MS        10
// Cycles per 10 ms step at the system clock rate.
`define ROC_TICK_CYCLES    (`ROC_TICK_MS * 1000 * `ROC_CLK_MHZ)
// Largest setting in 10 ms steps, 300.00 s.
`define ROC_TIME_MAX       15'h7530
// Default time setting, 0.00 s.
`define ROC_TIME_DEF       15'h0000

`endif

/* common/roc_pkg.sv */
/*
 * Types for the relay output conditioner.
 * Assumes roc_regs.svh is available on the include path.
 */
`include "roc_regs.svh"

package roc_pkg;

    typedef logic [`ROC_SEL_W-1:0]  roc_sel_t;
    typedef logic [`ROC_TIME_W-1:0] roc_time_t;

    // Per-slot assignment: selector into the signal list and its inversion.
    typedef struct packed {
        roc_sel_t sel;
        logic     invert;
    } roc_slot_s;

    // Output-side settings.
    typedef struct packed {
        roc_time_t t_hold;
        roc_time_t t_off_delay;
        logic      latched;
        roc_sel_t  ack_sel;
        logic      out_invert;
    } roc_cfg_s;

    typedef enum logic [2:0] {
        ROC_OFF     = 3'b001,
        ROC_ON      = 3'b010,
        ROC_OFF_DLY = 3'b100
    } roc_state_e;

endpackage

/* verif/roc_relay_output_chk.sv */
/* Assertions for the relay output conditioner.
   Sees only the top ports; bound in below. */
`timescale 1ns/100ps
`include "roc_regs.svh"
module roc_relay_output_chk
    import roc_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic [`ROC_SIG_W-1:0] sig_list,
    input wire roc_slot_s             slot_cfg [`ROC_NUM_SLOTS],
    input wire roc_cfg_s              cfg,
    input wire logic                  relay_drive,
    input wire logic                  relay_request,
    input wire logic                  relay_latched
);
    logic [`ROC_NUM_SLOTS-1:0] hit;
    logic                      rq;
    logic                      on;
    logic                      ack;
    for (genvar i = 0; i < `ROC_NUM_SLOTS; i++) begin : g_s
        assign hit[i] = slot_cfg[i].sel != `ROC_SEL_NONE &&
                        (sig_list[slot_cfg[i].sel] ^ slot_cfg[i].invert);
    end
    assign rq  = |hit;
    assign on  = relay_drive ^ cfg.out_invert;
    assign ack = cfg.ack_sel != `ROC_SEL_NONE && sig_list[cfg.ack_sel];
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_rel;
        relay_latched && ack && !relay_request;
    endsequence
    a_req_or: assert property ($past(reset_n) |-> relay_request == $past(rq))
        else $error("request is not the OR of the slots");
    a_off_fast: assert property (cfg.t_hold == 0 && cfg.t_off_delay == 0
        && !cfg.latched && $fell(relay_request) |-> ##[0:6] !on) else $error("late off");
    a_hold_min: assert property (cfg.t_hold != 0 && $past(reset_n, 2)
        && $changed(relay_drive) |=> $stable(relay_drive) [*3]) else $error("hold cut");
    a_off_dly: assert property (cfg.t_off_delay >= 3 && on && $fell(relay_request)
        |=> on [*4]) else $error("off delay cut");
    a_latch_set: assert property (cfg.latched && $rose(relay_request)
        |-> ##[0:2] relay_latched) else $error("latch not set");
    a_latch_keep: assert property (relay_latched && !ack && !$past(ack)
        |=> relay_latched && on) else $error("latch lost");
    a_ack_rel: assert property (s_rel |-> ##[1:3] !relay_latched)
        else $error("ack did not release");
    a_no_latch: assert property (!cfg.latched |-> !relay_latched)
        else $error("latched while disabled");
    a_rst_off: assert property (!$past(reset_n, 2) && $past(reset_n) && !relay_request
        |-> relay_drive == cfg.out_invert) else $error("bad off level");
endmodule

bind roc_relay_output roc_relay_output_chk roc_relay_output_chk_i (.clk(clk), .reset_n(reset_n),
    .sig_list(sig_list), .slot_cfg(slot_cfg), .cfg(cfg), .relay_drive(relay_drive),
    .relay_request(relay_request), .relay_latched(relay_latched));

/* verif/tb_roc_relay_output.sv */
/* Testbench for the relay output conditioner.
   Drives all ports directly; the 10 ms step is cut to 4 cycles. */
`timescale 1ns/100ps
`include "roc_regs.svh"
module tb_roc_relay_output
    import roc_pkg::*;
;
    logic                  clk      = 1'b0;
    logic                  reset_n  = 1'b0;
    logic [`ROC_SIG_W-1:0] sig      = '0;
    roc_slot_s             slot [`ROC_NUM_SLOTS] = '{default: '0};
    roc_cfg_s              cfg      = '0;
    logic                  drive;
    logic                  request;
    logic                  latched;
    int                    errors   = 0;
    int                    n_checks = 0;
    roc_relay_output #(.TICK_CYCLES(4)) roc_relay_output_i (.clk(clk), .reset_n(reset_n),
        .sig_list(sig), .slot_cfg(slot), .cfg(cfg), .relay_drive(drive),
        .relay_request(request), .relay_latched(latched));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic setup(input roc_cfg_s c, input int k, input roc_slot_s s);
        @(posedge clk);
        reset_n <= 1'b0;
        cfg     <= c;
        sig     <= '0;
        for (int i = 0; i < `ROC_NUM_SLOTS; i++) slot[i] <= (i == k) ? s : roc_slot_s'(4'h0);
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    task automatic expect_bit(input logic got, input logic e);
        n_checks++;
        if (got !== e) begin
            errors++;
            $display("ERROR %0t output %b expected %b", $time, got, e);
        end
    endtask
    task automatic step(input logic [7:0] v, input int n, input logic e);
        @(posedge clk);
        sig <= v;
        repeat (n) @(posedge clk);
        #1;
        expect_bit(drive, e);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        setup('{15'h0, 15'h0, 1'b0, 3'h0, 1'b0}, 6, '{3'h7, 1'b0});
        step(8'h80, 2, 1'b1);
        expect_bit(request, 1'b1);
        step(8'h00, 6, 1'b0);
        expect_bit(request, 1'b0);
        setup('{15'h0, 15'h0, 1'b0, 3'h0, 1'b0}, 2, '{3'h3, 1'b1});
        step(8'h00, 2, 1'b1);
        step(8'h08, 6, 1'b0);
        setup('{15'h0, 15'h0, 1'b0, 3'h0, 1'b0}, 0, '{3'h0, 1'b1});
        step(8'hff, 3, 1'b0);
        setup('{15'h0, 15'h0, 1'b0, 3'h0, 1'b1}, 0, '{3'h1, 1'b0});
        step(8'h02, 2, 1'b0);
        step(8'h00, 6, 1'b1);
        setup('{15'h0, 15'h0, 1'b1, 3'h2, 1'b0}, 0, '{3'h1, 1'b0});
        step(8'h02, 2, 1'b1);
        step(8'h00, 10, 1'b1);
        expect_bit(latched, 1'b1);
        step(8'h04, 8, 1'b0);
        expect_bit(latched, 1'b0);
        setup('{15'h0, 15'h0, 1'b0, 3'h2, 1'b0}, 0, '{3'h1, 1'b0});
        step(8'h06, 3, 1'b1);
        expect_bit(latched, 1'b0);
        step(8'h04, 6, 1'b0);
        setup('{15'h0, 15'h3, 1'b0, 3'h0, 1'b0}, 0, '{3'h1, 1'b0});
        step(8'h02, 2, 1'b1);
        step(8'h00, 5, 1'b1);
        step(8'h00, 16, 1'b0);
        setup('{15'h3, 15'h0, 1'b0, 3'h0, 1'b0}, 0, '{3'h1, 1'b0});
        step(8'h02, 2, 1'b1);
        step(8'h00, 4, 1'b1);
        step(8'h00, 20, 1'b0);
        finish_test();
    end
    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        finish_test();
    end
endmodule
